// File: rmw_pkg.sv
// Contract
// - RMW cycle: one read transfer then one write transfer in one bus cycle.
// - Slave acks read with valid data and tag; master captures at ack.
// - Master may drop stb after read ack; slave deasserts ack meanwhile.
// - Slave may stall write ack until ready to accept write data.
// - Slave captures write data on edge where it acks with stb and we.
// - Master drops stb and cyc after write ack; slave then drops ack.
// - RMW support optional; when supported the sequence is exact.
// - Big endian: most significant part at the lower address.
// - Little endian: most significant part at the higher address.
// - Units are byte 8, word 16, dword 32 and qword 64 bits.
// - Never transfer an operand smaller than the port granularity; slave acks an empty select, sets gran_err_ff, stores nothing.
// - 64-bit port carries 64-bit operand at once, msb on bit 63.
// - 32-bit port splits 64-bit operand; big endian high dword low address.
// - Little endian on 32-bit port: low dword at the lower address.
// - Big endian 64-bit operand: byte 0 in the bit 63 lane, descending.
// - Little endian 64-bit operand: byte 0 in the bit 0 lane, ascending.
// - Port size, granularity, max operand each 8, 16, 32 or 64 bits.
// - Port size equal to granularity makes both orders identical.
// - Piece order is application specific; lower to higher addresses used.
// - All bus outputs are registered; inputs sampled on the rising edge.
package rmw_pkg;

  // ---------------------------------------------------------------
  // Sizes and layout
  // ---------------------------------------------------------------
  localparam int RMW_BYTE_W  = 8;
  localparam int RMW_WORD_W  = 16;
  localparam int RMW_DWORD_W = 32;
  localparam int RMW_QWORD_W = 64;
  localparam int RMW_ADR_W   = 32;
  localparam int RMW_TAG_W   = 4;
  localparam int RMW_MEM_AW  = 4;
  localparam int RMW_OP_UNITS = RMW_QWORD_W / RMW_DWORD_W;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [RMW_DWORD_W-1:0] RMW_MEM_RST   = 32'h0000_0000;
  localparam logic [RMW_TAG_W-1:0]   RMW_TAG_RST   = 4'h0;
  localparam logic                   RMW_BIG_RST   = 1'b1;

  // ---------------------------------------------------------------
  // Slave phase of a cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RMW_IDLE,
    RMW_READ_DONE,
    RMW_WRITE_DONE
  } rmw_phase_e;

endpackage

// File: rmw_lane_map.sv
// Lane mapper that places operand bytes onto a port in either endian order.
`timescale 1ns/1ps
module rmw_lane_map #(
  parameter int PORT_W = 32,
  parameter int GRAN_W = 8
)(
  // Operand side
  input  wire logic [PORT_W-1:0] val_in,
  input  wire logic              big_endian,
  // Lane side
  output logic      [PORT_W-1:0] lanes_out
);
  localparam int NUNITS = PORT_W / GRAN_W;

  // Unit i of the value sits in lane i for little endian and in the
  // mirrored lane for big endian; identical when NUNITS is one.
  genvar i;
  generate
    for (i = 0; i < NUNITS; i++)
    begin : g_unit
      assign lanes_out[i*GRAN_W +: GRAN_W] = big_endian ?
        val_in[(NUNITS-1-i)*GRAN_W +: GRAN_W] :
        val_in[i*GRAN_W +: GRAN_W];
    end
  endgenerate
endmodule

// File: rmw_slave.sv
// Bus slave with read-modify-write support and endian-aware lane mapping.
`timescale 1ns/1ps
module rmw_slave #(
  parameter int PORT_W = 32,
  parameter int GRAN_W = 8,
  parameter int MAX_OP_W = 64,
  parameter int WAIT_W = 4
)(
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Bus inputs from the master
  input  wire logic                         cyc_o,
  input  wire logic                         stb_o,
  input  wire logic                         we_o,
  input  wire logic [rmw_pkg::RMW_ADR_W-1:0] adr_o,
  input  wire logic [rmw_pkg::RMW_TAG_W-1:0] tag_o,
  input  wire logic [PORT_W/GRAN_W-1:0]     sel_o,
  input  wire logic [PORT_W-1:0]            dat_o,
  // Bus outputs to the master
  output logic                              ack_i,
  output logic      [PORT_W-1:0]            dat_i,
  output logic      [rmw_pkg::RMW_TAG_W-1:0] tag_i,
  // Configuration and status
  input  wire logic                         big_endian,
  input  wire logic [WAIT_W-1:0]            write_wait,
  output logic                              rmw_done_ff,
  output logic                              rmw_active_ff,
  output logic                              gran_err_ff
);
  localparam int NSEL = PORT_W / GRAN_W;
  localparam int DEPTH = 1 << rmw_pkg::RMW_MEM_AW;
  localparam int ADR_LSB = $clog2(PORT_W / 8);

  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [PORT_W-1:0]              mem_ff [DEPTH];
  rmw_pkg::rmw_phase_e            phase_ff;
  logic [WAIT_W-1:0]              wait_cnt_ff;
  logic [rmw_pkg::RMW_ADR_W-1:0]  rd_adr_ff;
  logic [rmw_pkg::RMW_MEM_AW-1:0] idx;
  logic                           req;
  logic                           wr_ready;
  logic [PORT_W-1:0]              rd_lanes;
  logic [PORT_W-1:0]              wr_val;
  logic                           sel_ok;
  logic                           rd_hit;
  logic                           wr_hit;

  assign idx = adr_o[ADR_LSB +: rmw_pkg::RMW_MEM_AW];
  assign req = cyc_o && stb_o && !ack_i;
  assign wr_ready = (wait_cnt_ff >= write_wait);

  // A select may only address whole granules; an empty select would mean
  // a sub-granule operand, which the port still acks but flags in gran_err_ff and never stores.
  assign sel_ok = (sel_o != '0);
  assign rd_hit = req && !we_o;
  assign wr_hit = req && we_o && wr_ready;

  // ---------------------------------------------------------------
  // Lane mapping, one mapper per direction
  // ---------------------------------------------------------------
  rmw_lane_map #(.PORT_W(PORT_W), .GRAN_W(GRAN_W)) u_rd_map (
    .val_in    (mem_ff[idx]),
    .big_endian(big_endian),
    .lanes_out (rd_lanes)
  );

  rmw_lane_map #(.PORT_W(PORT_W), .GRAN_W(GRAN_W)) u_wr_map (
    .val_in    (dat_o),
    .big_endian(big_endian),
    .lanes_out (wr_val)
  );

  // ---------------------------------------------------------------
  // Acknowledge and read data, registered
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_i <= 1'b0;
      dat_i <= '0;
      tag_i <= rmw_pkg::RMW_TAG_RST;
    end
    else
    begin
      ack_i <= rd_hit || wr_hit;
      if (rd_hit)
      begin
        dat_i <= rd_lanes;
        tag_i <= tag_o;
      end
      else if (wr_hit)
        tag_i <= tag_o;
    end
  end

  // ---------------------------------------------------------------
  // Write wait counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_cnt_ff <= '0;
    else if (cyc_o && stb_o && we_o && !wr_ready)
      wait_cnt_ff <= wait_cnt_ff + 1'b1;
    else if (!(cyc_o && stb_o && we_o))
      wait_cnt_ff <= '0;
  end

  // ---------------------------------------------------------------
  // Memory write, lane by lane under select
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < DEPTH; k++)
        mem_ff[k] <= rmw_pkg::RMW_MEM_RST[PORT_W-1:0];
    end
    else if (wr_hit && sel_ok)
    begin
      for (int s = 0; s < NSEL; s++)
        if (sel_o[big_endian ? NSEL-1-s : s])
          mem_ff[idx][s*GRAN_W +: GRAN_W] <= wr_val[s*GRAN_W +: GRAN_W];
    end
  end

  // ---------------------------------------------------------------
  // RMW phase tracking
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_ff      <= rmw_pkg::RMW_IDLE;
      rd_adr_ff     <= '0;
      rmw_done_ff   <= 1'b0;
      rmw_active_ff <= 1'b0;
    end
    else
    begin
      rmw_done_ff <= 1'b0;
      if (!cyc_o)
      begin
        phase_ff      <= rmw_pkg::RMW_IDLE;
        rmw_active_ff <= 1'b0;
      end
      else
      begin
        unique case (phase_ff)
          rmw_pkg::RMW_IDLE:
            if (rd_hit)
            begin
              phase_ff      <= rmw_pkg::RMW_READ_DONE;
              rd_adr_ff     <= adr_o;
              rmw_active_ff <= 1'b1;
            end
          rmw_pkg::RMW_READ_DONE:
            if (wr_hit && adr_o == rd_adr_ff)
            begin
              phase_ff    <= rmw_pkg::RMW_WRITE_DONE;
              rmw_done_ff <= 1'b1;
            end
          rmw_pkg::RMW_WRITE_DONE:
            phase_ff <= rmw_pkg::RMW_WRITE_DONE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Granularity violation flag, sticky until the next acknowledged transfer with a non-empty select
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      gran_err_ff <= 1'b0;
    else if (req && !sel_ok)
      gran_err_ff <= 1'b1;
    else if (rd_hit || wr_hit)
      gran_err_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  ack_in_cycle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ack_i |-> $past(cyc_o) && $past(stb_o))
    else $error("ack outside an active strobe");

  ack_single_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ack_i |=> !ack_i)
    else $error("ack held for two cycles");

  ack_drop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !stb_o |=> !ack_i)
    else $error("ack after strobe dropped");

  ack_nocyc_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !cyc_o |=> !ack_i)
    else $error("ack without an active cycle");

  // ---------------------------------------------------------------
  // Checks on the read half
  // ---------------------------------------------------------------
  read_ack_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cyc_o && stb_o && !we_o && !ack_i) |=> ack_i)
    else $error("read not acknowledged next cycle");

  rd_data_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ack_i && !$past(we_o)) |-> dat_i == $past(rd_lanes))
    else $error("read data not taken from storage");

  dat_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !$past(rd_hit) |-> $stable(dat_i))
    else $error("read data changed without a read");

  tag_echo_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ack_i |-> tag_i == $past(tag_o))
    else $error("tag not echoed");

  tag_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !$past(rd_hit || wr_hit) |-> $stable(tag_i))
    else $error("tag changed without an ack");

  rd_keep_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rd_hit |=> mem_ff[$past(idx)] == $past(mem_ff[idx]))
    else $error("read half changed storage");

  // ---------------------------------------------------------------
  // Checks on the write half
  // ---------------------------------------------------------------
  write_wait_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (ack_i && $past(we_o)) |-> $past(wait_cnt_ff >= write_wait))
    else $error("write acked before ready");

  write_stall_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cyc_o && stb_o && we_o && !ack_i && !wr_ready)
      |=> !ack_i)
    else $error("write acked during a wait state");

  write_ack_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cyc_o && stb_o && we_o && !ack_i && wr_ready)
      |=> ack_i)
    else $error("ready write not acknowledged");

  wait_step_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (cyc_o && stb_o && we_o && !wr_ready)
      |=> wait_cnt_ff == $past(wait_cnt_ff) + 1'b1)
    else $error("write wait count did not advance");

  wait_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !(cyc_o && stb_o && we_o) |=> wait_cnt_ff == '0)
    else $error("write wait count not cleared");

  wr_capture_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_hit && sel_o[big_endian ? NSEL-1 : 0] && sel_ok)
      |=> mem_ff[$past(idx)][GRAN_W-1:0] == $past(wr_val[GRAN_W-1:0]))
    else $error("write data not captured");

  gran_keep_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (req && !sel_ok) |=> mem_ff[$past(idx)] == $past(mem_ff[idx]))
    else $error("empty select changed storage");

  gran_set_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (req && !sel_ok) |=> gran_err_ff)
    else $error("empty select not flagged");

  // ---------------------------------------------------------------
  // Checks on cycle state
  // ---------------------------------------------------------------
  rmw_done_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rmw_done_ff |-> ack_i && $past(we_o) && $past(phase_ff)
      == rmw_pkg::RMW_READ_DONE)
    else $error("rmw done without read then write");

  done_pulse_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rmw_done_ff |=> !rmw_done_ff)
    else $error("rmw done longer than one cycle");

  done_addr_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rmw_done_ff |-> $past(adr_o) == $past(rd_adr_ff))
    else $error("rmw done on a different address");

  active_set_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (rd_hit && phase_ff == rmw_pkg::RMW_IDLE)
      |=> rmw_active_ff)
    else $error("rmw active not raised by the read");

  active_clr_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !cyc_o |=> !rmw_active_ff && phase_ff == rmw_pkg::RMW_IDLE)
    else $error("rmw state kept after the cycle ended");

  size_legal_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (PORT_W inside {rmw_pkg::RMW_BYTE_W, rmw_pkg::RMW_WORD_W,
      rmw_pkg::RMW_DWORD_W, rmw_pkg::RMW_QWORD_W}) &&
    (GRAN_W inside {rmw_pkg::RMW_BYTE_W, rmw_pkg::RMW_WORD_W,
      rmw_pkg::RMW_DWORD_W, rmw_pkg::RMW_QWORD_W}) &&
    (GRAN_W <= PORT_W) && (MAX_OP_W >= GRAN_W))
    else $error("port size or granularity not legal");

  // ---------------------------------------------------------------
  // Lane order checks
  // ---------------------------------------------------------------
  // Each bus lane is held against the storage lane that the endian
  // order names for it, in both directions.
  genvar g;
  generate
    for (g = 0; g < NSEL; g++)
    begin : g_lane_chk
      rd_lane_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ack_i && !$past(we_o)) |-> dat_i[g*GRAN_W +: GRAN_W] ==
          $past(mem_ff[idx][(big_endian ? NSEL-1-g : g)*GRAN_W +: GRAN_W]))
        else $error("read lane out of order");

      wr_lane_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_hit && sel_ok && sel_o[g]) |=>
          mem_ff[$past(idx)][($past(big_endian) ? NSEL-1-g : g)*GRAN_W
            +: GRAN_W] == $past(dat_o[g*GRAN_W +: GRAN_W]))
        else $error("write lane out of order");
    end
  endgenerate

endmodule

// File: rmw_master_model.sv
// Bus master model that issues read-modify-write cycles to the slave.
`timescale 1ns/1ps
module rmw_master_model (
  // Clock
  input  wire logic                          core_clk,
  // Bus outputs
  output logic                               cyc_o,
  output logic                               stb_o,
  output logic                               we_o,
  output logic [rmw_pkg::RMW_ADR_W-1:0]      adr_o,
  output logic [rmw_pkg::RMW_TAG_W-1:0]      tag_o,
  output logic [3:0]                         sel_o,
  output logic [31:0]                        dat_o,
  // Bus inputs
  input  wire logic                          ack_i,
  input  wire logic [31:0]                   dat_i,
  input  wire logic [rmw_pkg::RMW_TAG_W-1:0] tag_i
);
  initial
  begin
    {cyc_o, stb_o, we_o, adr_o, tag_o, sel_o} = '0;
    dat_o = 32'hA5A5_A5A5;
  end

  // One strobed transfer; returns captured data, tag and edges waited.
  task automatic xfer(input logic we, input logic [31:0] adr,
    input logic [3:0] tag, input logic [3:0] sel, input logic [31:0] wd,
    output logic [31:0] rd, output logic [3:0] rt, output int n);
    n = 0;
    @(negedge core_clk);
    we_o  = we;
    adr_o = adr;
    tag_o = tag;
    sel_o = sel;
    dat_o = wd;
    cyc_o = 1'b1;
    stb_o = 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack_i !== 1'b1 && n < 40);
    rd = dat_i;
    rt = tag_i;
    @(negedge core_clk);
    stb_o = 1'b0;
    // A released data bus must not keep showing the last value.
    dat_o = ~dat_o;
  endtask

  task automatic rmw(input logic [31:0] adr, input logic [3:0] tag,
    input logic [3:0] sel_w, input logic [31:0] wd, input int gap,
    output logic [31:0] rd, output logic [3:0] rt, output int nr,
    output int nw);
    logic [31:0] d;
    logic [3:0]  t;
    xfer(1'b0, adr, tag, 4'hF, 32'h0, rd, rt, nr);
    repeat (gap) @(negedge core_clk);
    xfer(1'b1, adr, tag, sel_w, wd, d, t, nw);
    cyc_o = 1'b0;
  endtask

  // Strobe without a cycle, which the slave must ignore.
  task automatic stray(input int n);
    @(negedge core_clk);
    stb_o = 1'b1;
    repeat (n) @(negedge core_clk);
    stb_o = 1'b0;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the read-modify-write slave.
`timescale 1ns/1ps
module testbench;
  logic        core_clk, rst_n, big_endian, cyc_o, stb_o, we_o, ack_i;
  logic        rmw_done_ff, rmw_active_ff, gran_err_ff, done_seen, be;
  logic        act_seen;
  logic [3:0]  write_wait, tag_o, tag_i, sel_o, tag, sel_w, rt;
  logic [31:0] adr_o, dat_o, dat_i, rd, wd, exp_rd, wv;
  logic [31:0] mem [16];
  int          err_count, compares, idx, ww, nr, nw;

  rmw_slave #(.PORT_W(32), .GRAN_W(8), .MAX_OP_W(64), .WAIT_W(4))
  i_rmw_slave (.core_clk(core_clk), .rst_n(rst_n), .cyc_o(cyc_o),
    .stb_o(stb_o), .we_o(we_o), .adr_o(adr_o), .tag_o(tag_o),
    .sel_o(sel_o), .dat_o(dat_o), .ack_i(ack_i), .dat_i(dat_i),
    .tag_i(tag_i), .big_endian(big_endian), .write_wait(write_wait),
    .rmw_done_ff(rmw_done_ff), .rmw_active_ff(rmw_active_ff),
    .gran_err_ff(gran_err_ff));

  rmw_master_model i_master (.core_clk(core_clk), .cyc_o(cyc_o),
    .stb_o(stb_o), .we_o(we_o), .adr_o(adr_o), .tag_o(tag_o),
    .sel_o(sel_o), .dat_o(dat_o), .ack_i(ack_i), .dat_i(dat_i),
    .tag_i(tag_i));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] view(logic [31:0] d, logic b);
    return b ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic chk_flag(string nm, logic e, logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk)
    if (ack_i === 1'b1 && we_o === 1'b1 && stb_o === 1'b1)
    begin
      done_seen <= rmw_done_ff;
      act_seen  <= rmw_active_ff;
    end
    else if (ack_i === 1'b1)
    begin
      done_seen <= 1'b0;
      act_seen  <= 1'b0;
    end

  // Acknowledge may only be visible while a strobed cycle stands.
  always @(negedge core_clk)
    if (!(cyc_o === 1'b1 && stb_o === 1'b1))
      chk_flag("ack_idle", 1'b0, ack_i);

  initial
  begin
    {err_count, compares, rst_n} = '0;
    {big_endian, write_wait} = '0;
    foreach (mem[i]) mem[i] = 32'h0;
    void'($urandom(32'h18D0));
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    chk("reset_out", 32'h0, {ack_i, dat_i[26:0], tag_i});
    i_master.stray(4);
    for (int k = 0; k < 14; k++)
    begin
      idx = $urandom_range(15);
      be = $urandom_range(1);
      ww = (k == 0) ? 0 : (k == 1) ? 15 : $urandom_range(6);
      sel_w = (k == 2) ? 4'h0 : (k == 3) ? 4'hF : 4'($urandom_range(15));
      tag = 4'($urandom_range(15));
      wd = $urandom;
      @(negedge core_clk);
      big_endian = be;
      write_wait = 4'(ww);
      exp_rd = view(mem[idx], be);
      i_master.rmw({26'h0, 4'(idx), 2'b00}, tag, sel_w, wd,
        $urandom_range(3), rd, rt, nr, nw);
      chk("read_data", exp_rd, rd);
      chk("read_tag", {28'h0, tag}, {28'h0, rt});
      chk("read_wait", 32'd2, nr);
      chk("write_wait", 32'(2 + ww), nw);
      chk_flag("rmw_done", 1'b1, done_seen);
      chk_flag("rmw_active_hi", 1'b1, act_seen);
      chk_flag("gran_err", sel_w == 4'h0, gran_err_ff);
      wv = view(wd, be);
      for (int i = 0; i < 4; i++)
        if ((be ? sel_w[3-i] : sel_w[i]) === 1'b1)
          mem[idx][8*i+:8] = wv[8*i+:8];
      @(negedge core_clk);
      chk_flag("rmw_active", 1'b0, rmw_active_ff);
      $display("test %0d done", k);
      if (nr >= 40 || nw >= 40)
      begin
        err_count++;
        finish_test();
      end
    end
    finish_test();
  end
endmodule
